// file: rtl/dcrg_regs.v
// APB register bank configuring the on-chip switching regulator and its oscillator.
// Assumes an APB master on CLK; the oscillator clock arrives asynchronous on OSC_CLK.
//
// Register access over APB was decided locally.
`timescale 1ns/1ps
`include "dcrg_map.vh"

module dcrg_regs (
  input wire CLK,
  input wire RESET_N,
  input wire OSC_CLK,
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [11:0] PADDR,
  input wire [31:0] PWDATA,
  output reg [31:0] PRDATA,
  output reg PREADY,
  output reg PSLVERR,
  input wire REF_UPDATE_VALID,
  input wire [6:0] REF_UPDATE_CODE,
  output reg [31:0] LN_COMP_TRIM,
  output reg [6:0] LOW_NOISE_REF_TRIM,
  output reg LOW_NOISE_FEEDBACK_ATTEN,
  output reg [7:0] LOW_POWER_REF_SELECT,
  output reg LOW_POWER_FEEDBACK_ATTEN,
  output reg [1:0] LOW_POWER_BLANKING,
  output reg BIAS_DUTY_CYCLE_ENABLE,
  output reg [3:0] SLEEP_COMPARATOR_HYSTERESIS,
  output reg [4:0] OSCILLATOR_INTERNAL_TRIM,
  output reg [2:0] OSCILLATOR_BAND_SELECT,
  output wire [31:0] OSC_REG_CTRL,
  output reg IRQ
);
  reg [31:0] ln_comp_q;
  reg [31:0] ln_volt_q;
  reg [31:0] lp_volt_q;
  reg [31:0] lp_ctrl_q;
  reg [31:0] ln_freq_q;
  reg [31:0] reg_ctrl_q;
  reg [2:0] irq_stat_q;
  reg [2:0] irq_mask_q;
  reg ref_vld_s1_q;
  reg ref_vld_s2_q;
  reg ref_vld_s3_q;
  reg [6:0] ref_code_s1_q;
  reg [6:0] ref_code_s2_q;
  reg [31:0] rdata_d;
  reg err_d;
  wire xfer_busy;
  wire xfer_done;
  wire setup;
  wire wr;
  wire ref_evt;
  wire [2:0] irq_set;

  // Merge write data into the writable bits only, reserved bits stay zero
  function [31:0] merge;
    input [31:0] data;
    input [31:0] mask;
    begin
      merge = data & mask;
    end
  endfunction

  // Single setup cycle answered at the following access edge: zero wait states
  assign setup = PSEL && !PENABLE;
  assign wr = PSEL && PENABLE && PWRITE && PREADY;

  // Hardware update of reference trim comes from another domain, so synchronise
  // the valid level and the code; code must be stable while valid is high.
  always @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ref_vld_s1_q <= 1'b0;
      ref_vld_s2_q <= 1'b0;
      ref_vld_s3_q <= 1'b0;
      ref_code_s1_q <= 7'h00;
      ref_code_s2_q <= 7'h00;
    end else begin
      ref_vld_s1_q <= REF_UPDATE_VALID;
      ref_vld_s2_q <= ref_vld_s1_q;
      ref_vld_s3_q <= ref_vld_s2_q;
      ref_code_s1_q <= REF_UPDATE_CODE;
      ref_code_s2_q <= ref_code_s1_q;
    end
  end

  assign ref_evt = ref_vld_s2_q && !ref_vld_s3_q;

  // Control word crossing into the oscillator domain
  dcrg_xfer #(
    .W(32)
  ) dcrg_xfer_inst (
    .clk(CLK),
    .osc_clk(OSC_CLK),
    .reset_n(RESET_N),
    .start(wr && (PADDR == `DCRG_OFF_REG_CTRL)),
    .data(merge(PWDATA, `DCRG_MSK_REG_CTRL)),
    .busy_q(xfer_busy),
    .done_q(xfer_done),
    .osc_word_q(OSC_REG_CTRL)
  );

  // Configuration registers; one reset covers power-on, pin and brownout
  always @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ln_comp_q <= `DCRG_RST_LN_COMP;
      ln_volt_q <= `DCRG_RST_LN_VOLT;
      lp_volt_q <= `DCRG_RST_LP_VOLT;
      lp_ctrl_q <= `DCRG_RST_LP_CTRL;
      ln_freq_q <= `DCRG_RST_LN_FREQ;
      reg_ctrl_q <= `DCRG_RST_REG_CTRL;
      irq_mask_q <= 3'h0;
    end else begin
      if (wr && (PADDR == `DCRG_OFF_LN_COMP)) begin
        ln_comp_q <= merge(PWDATA, `DCRG_MSK_LN_COMP);
      end else if (wr && (PADDR == `DCRG_OFF_LN_VOLT)) begin
        ln_volt_q <= merge(PWDATA, `DCRG_MSK_LN_VOLT);
      end else if (wr && (PADDR == `DCRG_OFF_LP_VOLT)) begin
        lp_volt_q <= merge(PWDATA, `DCRG_MSK_LP_VOLT);
      end else if (wr && (PADDR == `DCRG_OFF_LP_CTRL)) begin
        lp_ctrl_q <= merge(PWDATA, `DCRG_MSK_LP_CTRL);
      end else if (wr && (PADDR == `DCRG_OFF_LN_FREQ)) begin
        ln_freq_q <= merge(PWDATA, `DCRG_MSK_LN_FREQ);
      end else if (wr && (PADDR == `DCRG_OFF_REG_CTRL) && !xfer_busy) begin
        // Write while busy is dropped: the crossing holds only one word
        reg_ctrl_q <= merge(PWDATA, `DCRG_MSK_REG_CTRL);
      end else if (wr && (PADDR == `DCRG_OFF_IRQ_MASK)) begin
        irq_mask_q <= PWDATA[2:0];
      end
      // Hardware reference update; a software write in the same cycle wins
      if (ref_evt && !(wr && (PADDR == `DCRG_OFF_LN_VOLT))) begin
        ln_volt_q[`DCRG_LNREF_MSB:`DCRG_LNREF_LSB] <= ref_code_s2_q;
      end
    end
  end

  // Sticky events: handshake done, hardware reference update, dropped write
  assign irq_set = {wr && (PADDR == `DCRG_OFF_REG_CTRL) && xfer_busy, ref_evt, xfer_done};

  // Set wins over a write-one clear in the same cycle
  always @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      irq_stat_q <= 3'h0;
    end else if (wr && (PADDR == `DCRG_OFF_IRQ_STAT)) begin
      irq_stat_q <= (irq_stat_q & ~PWDATA[2:0]) | irq_set;
    end else begin
      irq_stat_q <= irq_stat_q | irq_set;
    end
  end

  // Read decode; unmapped addresses answer with an error and zero data
  always @* begin
    rdata_d = 32'h0000_0000;
    err_d = 1'b0;
    if (PADDR == `DCRG_OFF_LN_COMP) begin
      rdata_d = ln_comp_q;
    end else if (PADDR == `DCRG_OFF_LN_VOLT) begin
      rdata_d = ln_volt_q;
    end else if (PADDR == `DCRG_OFF_LP_VOLT) begin
      rdata_d = lp_volt_q;
    end else if (PADDR == `DCRG_OFF_LP_CTRL) begin
      rdata_d = lp_ctrl_q;
    end else if (PADDR == `DCRG_OFF_LN_FREQ) begin
      rdata_d = ln_freq_q;
    end else if (PADDR == `DCRG_OFF_SYNC) begin
      rdata_d = {31'h0000_0000, xfer_busy};
    end else if (PADDR == `DCRG_OFF_REG_CTRL) begin
      rdata_d = reg_ctrl_q;
    end else if (PADDR == `DCRG_OFF_IRQ_STAT) begin
      rdata_d = {29'h0000_0000, irq_stat_q};
    end else if (PADDR == `DCRG_OFF_IRQ_MASK) begin
      rdata_d = {29'h0000_0000, irq_mask_q};
    end else begin
      err_d = 1'b1;
    end
  end

  // Bus answer registered in the setup cycle, so PREADY rises in the access phase
  always @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      PREADY <= 1'b0;
      PRDATA <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end else begin
      PREADY <= setup;
      PSLVERR <= setup && err_d;
      if (setup && !PWRITE) begin
        PRDATA <= rdata_d;
      end
    end
  end

  // Field outputs to the analog regulator, all from flops
  always @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      LN_COMP_TRIM <= `DCRG_RST_LN_COMP;
      LOW_NOISE_REF_TRIM <= 7'h71;
      LOW_NOISE_FEEDBACK_ATTEN <= 1'b0;
      LOW_POWER_REF_SELECT <= 8'hb4;
      LOW_POWER_FEEDBACK_ATTEN <= 1'b0;
      LOW_POWER_BLANKING <= 2'h1;
      BIAS_DUTY_CYCLE_ENABLE <= 1'b1;
      SLEEP_COMPARATOR_HYSTERESIS <= 4'h0;
      OSCILLATOR_INTERNAL_TRIM <= 5'h10;
      OSCILLATOR_BAND_SELECT <= 3'h0;
      IRQ <= 1'b0;
    end else begin
      // Comparator trim keeps its register positions; other fields are sliced here
      LN_COMP_TRIM <= ln_comp_q;
      LOW_NOISE_REF_TRIM <= ln_volt_q[14:8];
      LOW_NOISE_FEEDBACK_ATTEN <= ln_volt_q[1];
      LOW_POWER_REF_SELECT <= lp_volt_q[8:1];
      LOW_POWER_FEEDBACK_ATTEN <= lp_volt_q[0];
      // Internal fields are passed as written; software keeps them at reset
      LOW_POWER_BLANKING <= lp_ctrl_q[26:25];
      BIAS_DUTY_CYCLE_ENABLE <= lp_ctrl_q[24];
      SLEEP_COMPARATOR_HYSTERESIS <= lp_ctrl_q[15:12];
      OSCILLATOR_INTERNAL_TRIM <= ln_freq_q[28:24];
      OSCILLATOR_BAND_SELECT <= ln_freq_q[2:0];
      IRQ <= |(irq_stat_q & irq_mask_q);
    end
  end
endmodule

// file: rtl/dcrg_map.vh
// Register offsets, field positions, reset values and write masks for the regulator config bank.
// Assumes inclusion by bare name from rtl/ design files.
`ifndef DCRG_MAP_VH
`define DCRG_MAP_VH
// Byte offsets
`define DCRG_OFF_LN_COMP 12'h058
`define DCRG_OFF_LN_VOLT 12'h05c
`define DCRG_OFF_LP_VOLT 12'h064
`define DCRG_OFF_LP_CTRL 12'h06c
`define DCRG_OFF_LN_FREQ 12'h070
`define DCRG_OFF_SYNC 12'h078
`define DCRG_OFF_REG_CTRL 12'h080
`define DCRG_OFF_IRQ_STAT 12'h0c0
`define DCRG_OFF_IRQ_MASK 12'h0c4
// Reset values of whole registers
`define DCRG_RST_LN_COMP 32'h5720_4077
`define DCRG_RST_LN_VOLT 32'h0000_7100
`define DCRG_RST_LP_VOLT 32'h0000_0168
`define DCRG_RST_LP_CTRL 32'h0300_0000
`define DCRG_RST_LN_FREQ 32'h1000_0000
`define DCRG_RST_REG_CTRL 32'h0000_0000
// Writable bit masks; reserved bits read zero
`define DCRG_MSK_LN_COMP 32'hf730_f1f7
`define DCRG_MSK_LN_VOLT 32'h0000_7f02
`define DCRG_MSK_LP_VOLT 32'h0000_01ff
`define DCRG_MSK_LP_CTRL 32'h0700_f000
`define DCRG_MSK_LN_FREQ 32'h1f00_0007
`define DCRG_MSK_REG_CTRL 32'h0000_0003
// Field positions
`define DCRG_LNREF_LSB 8
`define DCRG_LNREF_MSB 14
`define DCRG_BUSY_BIT 0
// Interrupt status bits
`define DCRG_IRQ_DONE 0
`define DCRG_IRQ_REFUPD 1
`define DCRG_IRQ_W 2
`endif

// file: rtl/dcrg_xfer.v
// Handshake crossing of the regulator control word into the oscillator domain.
// Assumes the oscillator clock is asynchronous to CLK; both share the power-on reset.
`timescale 1ns/1ps
module dcrg_xfer #(
  parameter W = 32
) (
  input wire clk,
  input wire osc_clk,
  input wire reset_n,
  input wire start,
  input wire [W-1:0] data,
  output reg busy_q,
  output reg done_q,
  output reg [W-1:0] osc_word_q
);
  reg req_q;
  reg ack_q;
  reg req_s1_q;
  reg req_s2_q;
  reg req_s3_q;
  reg ack_s1_q;
  reg ack_s2_q;
  reg ack_s3_q;
  reg [W-1:0] hold_q;

  // Source side: hold word steady while toggle request is outstanding
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      req_q <= 1'b0;
      hold_q <= {W{1'b0}};
      busy_q <= 1'b0;
      done_q <= 1'b0;
      ack_s1_q <= 1'b0;
      ack_s2_q <= 1'b0;
      ack_s3_q <= 1'b0;
    end else begin
      ack_s1_q <= ack_q;
      ack_s2_q <= ack_s1_q;
      ack_s3_q <= ack_s2_q;
      done_q <= 1'b0;
      if (start && !busy_q) begin
        req_q <= ~req_q;
        hold_q <= data;
        busy_q <= 1'b1;
      end else if (busy_q && (ack_s2_q != ack_s3_q)) begin
        busy_q <= 1'b0;
        done_q <= 1'b1;
      end
    end
  end

  // Oscillator side: capture word once request toggle is seen, echo it back
  always @(posedge osc_clk or negedge reset_n) begin
    if (!reset_n) begin
      req_s1_q <= 1'b0;
      req_s2_q <= 1'b0;
      req_s3_q <= 1'b0;
      ack_q <= 1'b0;
      osc_word_q <= {W{1'b0}};
    end else begin
      req_s1_q <= req_q;
      req_s2_q <= req_s1_q;
      req_s3_q <= req_s2_q;
      if (req_s2_q != req_s3_q) begin
        osc_word_q <= hold_q;
        ack_q <= ~ack_q;
      end
    end
  end
endmodule

// file: verification/dcrg_regs_assertions.sv
// Port checker for the regulator config bank.
// Assumes it is bound onto dcrg_regs, one clock domain.
`timescale 1ns/1ps
module dcrg_chk (
  input wire CLK,
  input wire RESET_N,
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [11:0] PADDR,
  input wire [31:0] PWDATA,
  input wire [31:0] PRDATA,
  input wire PREADY,
  input wire [31:0] LN_COMP_TRIM,
  input wire [6:0] LOW_NOISE_REF_TRIM,
  input wire LOW_NOISE_FEEDBACK_ATTEN,
  input wire LOW_POWER_FEEDBACK_ATTEN,
  input wire BIAS_DUTY_CYCLE_ENABLE,
  input wire [3:0] SLEEP_COMPARATOR_HYSTERESIS,
  input wire [2:0] OSCILLATOR_BAND_SELECT
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  // Completed access; field copies lag the register by a cycle
  wire acc = PSEL && PENABLE && PREADY;
  wire wr = acc && PWRITE;
  a_ready_after_setup: assert property (PSEL && !PENABLE |=> PREADY)
    else $error("no ready after setup");
  a_comp_write: assert property (wr && PADDR == 12'h058 |=> ##1
    LN_COMP_TRIM == ($past(PWDATA, 2) & 32'hf730f1f7)) else $error("comp trim lost");
  a_ref_write: assert property (wr && PADDR == 12'h05c |=> ##1
    {LOW_NOISE_REF_TRIM, LOW_NOISE_FEEDBACK_ATTEN} ==
    {$past(PWDATA[14:8], 2), $past(PWDATA[1], 2)}) else $error("ref trim lost");
  a_lp_atten: assert property (wr && PADDR == 12'h064 |=> ##1
    LOW_POWER_FEEDBACK_ATTEN == $past(PWDATA[0], 2)) else $error("lp atten lost");
  a_duty_hyst: assert property (wr && PADDR == 12'h06c |=> ##1
    {BIAS_DUTY_CYCLE_ENABLE, SLEEP_COMPARATOR_HYSTERESIS} ==
    {$past(PWDATA[24], 2), $past(PWDATA[15:12], 2)}) else $error("lp ctrl lost");
  a_band_write: assert property (wr && PADDR == 12'h070 |=> ##1
    OSCILLATOR_BAND_SELECT == $past(PWDATA[2:0], 2)) else $error("band lost");
  a_busy_only_bit: assert property (acc && !PWRITE && PADDR == 12'h078 |->
    PRDATA[31:1] == 31'h0) else $error("sync status reserved bits set");
  a_reset_values: assert property ($rose(RESET_N) |-> LN_COMP_TRIM == 32'h57204077 &&
    LOW_NOISE_REF_TRIM == 7'h71 && !LOW_NOISE_FEEDBACK_ATTEN && !LOW_POWER_FEEDBACK_ATTEN &&
    BIAS_DUTY_CYCLE_ENABLE && SLEEP_COMPARATOR_HYSTERESIS == 4'h0 &&
    OSCILLATOR_BAND_SELECT == 3'h0) else $error("bad reset value");
endmodule

bind dcrg_regs dcrg_chk dcrg_chk_inst (.CLK(CLK), .RESET_N(RESET_N), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
  .PREADY(PREADY), .LN_COMP_TRIM(LN_COMP_TRIM), .LOW_NOISE_REF_TRIM(LOW_NOISE_REF_TRIM),
  .LOW_NOISE_FEEDBACK_ATTEN(LOW_NOISE_FEEDBACK_ATTEN),
  .LOW_POWER_FEEDBACK_ATTEN(LOW_POWER_FEEDBACK_ATTEN),
  .BIAS_DUTY_CYCLE_ENABLE(BIAS_DUTY_CYCLE_ENABLE),
  .SLEEP_COMPARATOR_HYSTERESIS(SLEEP_COMPARATOR_HYSTERESIS),
  .OSCILLATOR_BAND_SELECT(OSCILLATOR_BAND_SELECT));

// file: verification/dcrg_regs_tb.sv
// Self-checking bench for the regulator config bank.
// Assumes dcrg_regs and its bound checker are compiled before it.
`timescale 1ns/1ps
module dcdc_regulator_config_regs_tb_top;
  reg CLK = 0;
  reg OSC_CLK = 0;
  reg RESET_N = 0;
  reg PSEL = 0;
  reg PENABLE = 0;
  reg PWRITE = 0;
  reg [11:0] PADDR = 0;
  reg [31:0] PWDATA = 0;
  reg REF_UPDATE_VALID = 0;
  reg [6:0] REF_UPDATE_CODE = 0;
  wire [31:0] PRDATA;
  wire [31:0] LN_COMP_TRIM;
  wire [6:0] LOW_NOISE_REF_TRIM;
  wire [7:0] LOW_POWER_REF_SELECT;
  wire [1:0] LOW_POWER_BLANKING;
  wire [4:0] OSCILLATOR_INTERNAL_TRIM;
  wire [31:0] OSC_REG_CTRL;
  wire PREADY;
  wire PSLVERR;
  wire IRQ;
  reg [31:0] rdat;
  reg slv;
  integer num_errors = 0;
  integer comparisons = 0;

  // Oscillator deliberately unrelated in phase to CLK
  always #5 CLK = ~CLK;
  always #17 OSC_CLK = ~OSC_CLK;

  dcrg_regs dcrg_regs_inst (.CLK(CLK), .RESET_N(RESET_N), .OSC_CLK(OSC_CLK), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .REF_UPDATE_VALID(REF_UPDATE_VALID),
    .REF_UPDATE_CODE(REF_UPDATE_CODE), .LN_COMP_TRIM(LN_COMP_TRIM),
    .LOW_NOISE_REF_TRIM(LOW_NOISE_REF_TRIM), .LOW_NOISE_FEEDBACK_ATTEN(),
    .LOW_POWER_REF_SELECT(LOW_POWER_REF_SELECT), .LOW_POWER_FEEDBACK_ATTEN(),
    .LOW_POWER_BLANKING(LOW_POWER_BLANKING), .BIAS_DUTY_CYCLE_ENABLE(),
    .SLEEP_COMPARATOR_HYSTERESIS(), .OSCILLATOR_INTERNAL_TRIM(OSCILLATOR_INTERNAL_TRIM),
    .OSCILLATOR_BAND_SELECT(), .OSC_REG_CTRL(OSC_REG_CTRL), .IRQ(IRQ));

  task results;
    begin
      $display("errors %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask

  task chk(input [31:0] got, input [31:0] exp);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
    end
  endtask

  // One APB transfer; request held until ready is sampled high
  task xfer(input w, input [11:0] a, input [31:0] d);
    integer n;
    begin
      @(posedge CLK);
      PSEL <= 1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge CLK);
      PENABLE <= 1;
      n = 0;
      do begin
        @(posedge CLK);
        n = n + 1;
      end while (PREADY !== 1'b1 && n < 20);
      if (n >= 20) begin
        chk(32'h0, 32'h1);
        results;
      end
      rdat = PRDATA;
      slv = PSLVERR;
      PSEL <= 0;
      PENABLE <= 0;
    end
  endtask

  task rd(input [11:0] a, input [31:0] e);
    begin
      xfer(0, a, 32'h0);
      chk(rdat, e);
    end
  endtask

  task t_reset_vals;
    begin
      rd(12'h058, 32'h57204077);
      rd(12'h05c, 32'h00007100);
      rd(12'h064, 32'h00000168);
      rd(12'h06c, 32'h03000000);
      rd(12'h070, 32'h10000000);
      rd(12'h078, 32'h00000000);
      chk({17'h0, LOW_POWER_REF_SELECT, LOW_POWER_BLANKING, OSCILLATOR_INTERNAL_TRIM},
        {17'h0, 8'hb4, 2'h1, 5'h10});
      chk(OSC_REG_CTRL, 32'h0);
    end
  endtask

  // Boundary codes in every field, internal fields kept at reset
  task t_fields;
    begin
      xfer(1, 12'h058, 32'hf730f1f7);
      rd(12'h058, 32'hf730f1f7);
      xfer(1, 12'h058, 32'h0);
      repeat (2) @(posedge CLK);
      chk(LN_COMP_TRIM, 32'h0);
      xfer(1, 12'h05c, 32'h00007f02);
      repeat (2) @(posedge CLK);
      chk({25'h0, LOW_NOISE_REF_TRIM}, 32'h7f);
      xfer(1, 12'h064, 32'h000001ff);
      rd(12'h064, 32'h000001ff);
      xfer(1, 12'h06c, 32'h0200f000);
      rd(12'h06c, 32'h0200f000);
      xfer(1, 12'h070, 32'h10000007);
      rd(12'h070, 32'h10000007);
      chk({17'h0, LOW_POWER_REF_SELECT, LOW_POWER_BLANKING, OSCILLATOR_INTERNAL_TRIM},
        {17'h0, 8'hff, 2'h1, 5'h10});
    end
  endtask

  // Control crossing, busy poll and done interrupt
  task t_ctrl;
    integer n;
    begin
      xfer(1, 12'h0c4, 32'h1);
      xfer(1, 12'h080, 32'h1);
      rd(12'h078, 32'h1);
      n = 0;
      do begin
        xfer(0, 12'h078, 32'h0);
        n = n + 1;
      end while (rdat !== 32'h0 && n < 40);
      chk(rdat, 32'h0);
      chk(OSC_REG_CTRL, 32'h1);
      rd(12'h080, 32'h1);
      rd(12'h0c0, 32'h1);
      chk({31'h0, IRQ}, 32'h1);
      xfer(1, 12'h0c0, 32'h1);
      repeat (2) @(posedge CLK);
      chk({31'h0, IRQ}, 32'h0);
    end
  endtask

  // Hardware reference update, masked then unmasked
  task t_hw_ref;
    begin
      REF_UPDATE_CODE <= 7'h15;
      repeat (4) @(posedge CLK);
      REF_UPDATE_VALID <= 1;
      repeat (8) @(posedge CLK);
      REF_UPDATE_VALID <= 0;
      rd(12'h05c, 32'h00001502);
      chk({31'h0, IRQ}, 32'h0);
      xfer(1, 12'h0c4, 32'h2);
      repeat (2) @(posedge CLK);
      chk({31'h0, IRQ}, 32'h1);
      xfer(1, 12'h0c0, 32'h2);
      rd(12'h0c0, 32'h0);
    end
  endtask

  task t_errs;
    begin
      rd(12'h060, 32'h0);
      chk({31'h0, slv}, 32'h1);
      xfer(1, 12'h078, 32'h1);
      rd(12'h078, 32'h0);
    end
  endtask

  initial begin
    repeat (6) @(posedge CLK);
    RESET_N <= 1;
    t_reset_vals;
    t_fields;
    t_ctrl;
    t_hw_ref;
    t_errs;
    RESET_N <= 0;
    repeat (3) @(posedge CLK);
    RESET_N <= 1;
    t_reset_vals;
    results;
  end
endmodule
